// file: tb/rmpc_asserts.sv
// Purpose: port-level checks of the configuration bank
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound onto every rmpc_top instance
`timescale 1ns/1ps
module rmpc_asserts import rmpc_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register bus
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // radio side
  input rmpc_evt_s evt,
  input rmpc_cfg_s cfg,
  input rmpc_radio_e radio_state,
  input wire logic freq_loop_locked,
  input wire logic preamble_found,
  input rmpc_pins_s pins
);
  // ==========================================================================
  // bus handshake
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // one wait state, then the answer
  property p_answer;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  // answer lasts a single cycle
  property p_one;
    !waitrequest |=> waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("answer held too long");
  // the unmapped place at 12'h010 reads as zero
  property p_unmapped;
    read && !waitrequest && address == 12'h010 |-> readdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // ==========================================================================
  // configuration outputs
  property p_gain;
    write && !waitrequest && address == 12'h45C |-> ##2
      cfg.freq_loop_prop_gain == $past(writedata[7:4], 2) && cfg.freq_loop_int_gain == $past(writedata[3:0], 2);
  endproperty
  a_gain: assert property (p_gain) else $error("gain codes not applied");
  // factor is a power of two; skip the edge that leaves reset
  property p_factor;
    $past(rst_n) |-> cfg.int_gain_factor == (16'h0001 << cfg.freq_loop_int_gain);
  endproperty
  a_factor: assert property (p_factor) else $error("integral factor wrong");
  property p_phase;
    write && !waitrequest && address == 12'h460 |-> ##2 cfg.iq_phase_value == $past(writedata[6:0], 2);
  endproperty
  a_phase: assert property (p_phase) else $error("phase trim not applied");
  // ==========================================================================
  // radio behaviour
  property p_pa;
    radio_state == transmit_state && $past(radio_state) == transmit_state |->
      pins.test_pin_one == pins.test_pin_one_oe && !pins.test_pin_two;
  endproperty
  a_pa: assert property (p_pa) else $error("amplifier pins wrong in transmit");
  property p_no_turn;
    radio_state == transmit_state && evt.tx_end && !evt.packet_mode |=> radio_state == powered_on_state;
  endproperty
  a_no_turn: assert property (p_no_turn) else $error("turnaround outside packet mode");
  property p_lock_rx;
    freq_loop_locked |-> radio_state == receive_state;
  endproperty
  a_lock_rx: assert property (p_lock_rx) else $error("loop locked outside receive");
  property p_cal;
    radio_state == powered_off_state && evt.go_on |=> radio_state inside {filter_cal_state, powered_on_state};
  endproperty
  a_cal: assert property (p_cal) else $error("power on took a wrong path");
  // main scenarios seen
  c_found: cover property (preamble_found);
  c_cal: cover property (radio_state == filter_cal_state);
  c_turn: cover property (radio_state == transmit_state ##1 radio_state == synth_lock_state);
endmodule

bind rmpc_top rmpc_asserts i_chk (.*);

// file: tb/rmpc_top_test.sv
// Purpose: self-checking bench of the configuration bank
// Assumes: short calibration and lock counts through parameters
// Notes: model keeps register images in a small array
`timescale 1ns/1ps
module rmpc_top_test import rmpc_pkg::*;;
  // ==========================================================================
  // stimulus and observed signals
  logic clock = 0;
  logic rst_n = 0;
  logic read = 0;
  logic write = 0;
  logic [11:0] address = '0;
  logic [31:0] writedata = '0;
  logic [31:0] readdata, q;
  logic waitrequest, freq_loop_locked, preamble_found;
  logic [15:0] custom_lock_time = '0;
  rmpc_evt_s evt = '0;
  rmpc_cfg_s cfg;
  rmpc_radio_e radio_state;
  rmpc_pins_s pins;
  int miscompares = 0;
  int tests_run = 0;
  int nlk, saw;
  logic [7:0] m [5]; // model register images
  // event bit masks, same order as the event struct
  localparam logic [12:0] ev_off = 13'h0800, ev_on = 13'h0400, ev_rx = 13'h0200;
  localparam logic [12:0] ev_tx = 13'h0100, ev_pkt = 13'h0080, ev_txe = 13'h0040;
  localparam logic [12:0] ev_rxe = 13'h0020, ev_sync = 13'h0010, ev_pv = 13'h0008, ev_pe = 13'h0004;
  int tc [9] = '{12, 12, 11, 10, 9, 8, 8, 13, 0}; // tolerance codes tried
  int te [9] = '{0, 1, 1, 2, 3, 4, 5, 0, 0}; // wrong pairs sent

  always #10 clock = ~clock;

  // short counts keep the run brief
  rmpc_top #(.CAL_CYCLES(8), .LOCK_CYCLES(4)) i_dut (.*);

  // ==========================================================================
  // helpers
  task automatic end_sim;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic w, input int i, input logic [7:0] d);
    int n;
    address <= {i[9:0], 2'b00};
    read <= !w;
    write <= w;
    writedata <= 32'(d);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      miscompares++;
      end_sim;
    end
    q = readdata;
    read <= 0;
    write <= 0;
    @(posedge clock);
  endtask

  task automatic mode(input logic [7:0] v);
    bus(1, 'h11A, v);
    m[3] = v;
  endtask

  // one-cycle event pulse
  task automatic pulse(input logic [12:0] p);
    evt <= evt | p;
    @(posedge clock);
    evt <= evt & ~p;
    @(posedge clock);
  endtask

  // pulse, then wait for a state; notes calibration and lock cycles
  task automatic go(input logic [12:0] p, input rmpc_radio_e s);
    int n;
    evt <= evt | p;
    @(posedge clock);
    evt <= evt & ~p;
    saw = 0;
    nlk = 0;
    tests_run++;
    for (n = 0; n < 400 && radio_state !== s; n++) begin
      if (radio_state === filter_cal_state)
        saw = 1;
      if (radio_state === synth_lock_state)
        nlk++;
      @(posedge clock);
    end
    if (radio_state !== s) begin
      miscompares++;
      $display("ERROR %0t state %0d not reached", $time, s);
      end_sim;
    end
  endtask

  // fresh receive, twelve pairs with e wrong ones first
  task automatic pre(input int c, input int e);
    int k;
    bus(1, 'h11B, 8'(c));
    m[4] = 8'(c);
    go(ev_on, powered_on_state);
    go(ev_rx, receive_state);
    for (k = 0; k < 12; k++)
      pulse(ev_pv | (k < e ? ev_pe : 13'h0000));
    repeat (2) @(posedge clock);
    k = (c >= 8 && c <= 12 && e <= 12 - c);
    chk(preamble_found, k);
    chk(freq_loop_locked, k);
  endtask

  // ==========================================================================
  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    end_sim;
  end

  // ==========================================================================
  // main sequence
  initial begin
    int i, r;
    void'($urandom(60672));
    repeat (2) @(posedge clock);
    rst_n <= 1;
    m = '{8'h37, 8'h00, 8'h00, 8'h00, 8'h00};
    // read back, check applied fields, then random rewrite
    for (r = 0; r < 4; r++) begin
      for (i = 0; i < 5; i++) begin
        bus(0, 'h117 + i, 8'h00);
        chk(q, 32'(m[i]));
      end
      chk(cfg.prop_gain_factor, 16'h0001 << m[0][7:4]);
      chk(cfg.int_gain_factor, 16'h0001 << m[0][3:0]);
      chk(cfg.iq_phase_value, m[1][6:0]);
      chk(cfg.iq_amplitude_value, m[2][6:0]);
      chk({cfg.smart_wake_enable, cfg.wake_signal_qualify}, {m[3][7], m[3][5]});
      for (i = 0; i < 5; i++) begin
        m[i] = 8'($urandom);
        bus(1, 'h117 + i, m[i]);
      end
    end
    // unmapped place: write lost, read zero
    bus(1, 'h004, 8'hA5);
    bus(0, 'h004, 8'h00);
    chk(q, 32'h0000_0000);
    // calibration on power-up only when enabled
    mode(8'h40);
    go(ev_off, powered_off_state);
    go(ev_on, powered_on_state);
    chk(saw, 1);
    go(ev_off, powered_off_state);
    mode(8'h00);
    go(ev_on, powered_on_state);
    chk(saw, 0);
    // amplifier enables
    mode(8'h01);
    go(ev_tx, transmit_state);
    @(posedge clock);
    chk(pins, 4'hC);
    go(ev_txe, powered_on_state);
    mode(8'h02);
    go(ev_rx, receive_state);
    @(posedge clock);
    chk(pins, 4'h3);
    go(ev_on, powered_on_state);
    chk(pins, 4'h1);
    // turnaround in packet mode, then outside it
    evt <= evt | ev_pkt;
    mode(8'h18);
    go(ev_tx, transmit_state);
    go(ev_txe, receive_state);
    go(ev_rxe, transmit_state);
    evt <= evt & ~ev_pkt;
    mode(8'h18);
    go(ev_txe, powered_on_state);
    // custom against default lock time
    custom_lock_time <= 16'h0014;
    mode(8'h04);
    go(ev_rx, receive_state);
    chk(nlk >= 19 && nlk <= 23, 1);
    go(ev_on, powered_on_state);
    mode(8'h00);
    go(ev_rx, receive_state);
    chk(nlk <= 6, 1);
    // preamble tolerance table with loop in lock setting
    evt <= evt | 13'h0003;
    for (i = 0; i < 9; i++)
      pre(tc[i], te[i]);
    // detection off: sync word locks the loop
    pulse(ev_sync);
    chk(freq_loop_locked, 1);
    end_sim;
  end
endmodule

// file: verilog/rmpc_lock_timer.sv
// Purpose: times synthesizer settling before receive or transmit
// Assumes: start is a one-cycle pulse; custom time counted in clock cycles
// Notes: done is a one-cycle pulse from a flip-flop
`timescale 1ns/1ps
`include "rmpc_params.svh"
module rmpc_lock_timer import rmpc_pkg::*; #(
  parameter int LOCK_CYCLES = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic custom_en,
  input wire logic [15:0] custom_cycles,
  // result
  output logic done
);
  if (LOCK_CYCLES < 1 || LOCK_CYCLES > 65535) begin : g_chk
    $error("LOCK_CYCLES out of range");
  end

  rmpc_lock_s st; // current state
  rmpc_lock_s next_st; // next state

  // ==========================================================================
  // count down the selected lock time
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start) begin
      next_st.busy = 1'b1;
      // custom time of zero would wrap the counter and run 65536 cycles, so it acts as one cycle
      if (custom_en) begin
        next_st.cnt = (custom_cycles == 16'h0000) ? 16'h0001 : custom_cycles;
      end else begin
        next_st.cnt = 16'(LOCK_CYCLES);
      end
    end else if (st.busy) begin
      if (st.cnt == 16'h0001) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt - 16'h0001;
      end
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;
endmodule

// file: verilog/rmpc_params.svh
// Purpose: constants of the radio mode and preamble configuration bank
// Assumes: included by its bare name from every design file that needs it
// Notes: definitions only; offsets are register indices, byte address is four times the index
`ifndef RMPC_PARAMS_SVH
`define RMPC_PARAMS_SVH

// ==========================================================================
// register indices (byte address = index * 4)
`define RMPC_IDX_GAIN 10'h117
`define RMPC_IDX_PHASE 10'h118
`define RMPC_IDX_AMP 10'h119
`define RMPC_IDX_MODE 10'h11A
`define RMPC_IDX_PRE 10'h11B
`define RMPC_IDX_STATUS 10'h100

// ==========================================================================
// field positions
`define RMPC_KP_MSB 7
`define RMPC_KP_LSB 4
`define RMPC_KI_MSB 3
`define RMPC_KI_LSB 0
`define RMPC_TRIM_MSB 6
`define RMPC_BIT_SMART_WAKE 7
`define RMPC_BIT_FILTER_CAL 6
`define RMPC_BIT_WAKE_QUAL 5
`define RMPC_BIT_SEND_LISTEN 4
`define RMPC_BIT_LISTEN_SEND 3
`define RMPC_BIT_CUSTOM_LOCK 2
`define RMPC_BIT_AMP_RX 1
`define RMPC_BIT_AMP_TX 0
`define RMPC_TOL_MSB 3

// ==========================================================================
// reset values
`define RMPC_RST_GAIN 8'h37
`define RMPC_RST_ZERO 8'h00

// ==========================================================================
// preamble judging and loop settings
`define RMPC_PAIRS 4'hC
`define RMPC_TOL_OFF 4'h0
`define RMPC_LOCK_SETTING 2'h3

`endif

// file: verilog/rmpc_pkg.sv
// Purpose: types shared by the configuration bank and its helpers
// Assumes: constants live in rmpc_params.svh
// Notes: radio states are binary coded
package rmpc_pkg;

  // ==========================================================================
  // radio state of the device
  typedef enum logic [2:0] {
    powered_sleep_state = 3'b000,
    powered_off_state = 3'b001,
    powered_on_state = 3'b010,
    receive_state = 3'b011,
    transmit_state = 3'b100,
    filter_cal_state = 3'b101,
    synth_lock_state = 3'b110
  } rmpc_radio_e;

  // ==========================================================================
  // commands and events from the surrounding radio
  typedef struct packed {
    logic go_sleep; // pulse: sleep from powered off
    logic go_off; // pulse: power off
    logic go_on; // pulse: power on / leave rx or tx
    logic go_rx; // pulse: start receive
    logic go_tx; // pulse: start transmit
    logic packet_mode; // level: packet data mode selected
    logic tx_end; // pulse: packet transmission finished
    logic rx_valid_end; // pulse: valid packet received
    logic sync_found; // pulse: sync word matched
    logic pair_valid; // pulse: one preamble bit pair judged
    logic pair_err; // with pair_valid: pair was wrong
    logic [1:0] freq_loop_lock_setting; // frequency loop mode
  } rmpc_evt_s;

  // configuration applied to the datapath
  typedef struct packed {
    logic [3:0] freq_loop_prop_gain;
    logic [3:0] freq_loop_int_gain;
    logic [15:0] prop_gain_factor;
    logic [15:0] int_gain_factor;
    logic [6:0] iq_phase_value;
    logic [6:0] iq_amplitude_value;
    logic smart_wake_enable;
    logic wake_signal_qualify;
  } rmpc_cfg_s;

  // test pin drive: output and enable
  typedef struct packed {
    logic test_pin_one;
    logic test_pin_one_oe;
    logic test_pin_two;
    logic test_pin_two_oe;
  } rmpc_pins_s;

  // state of the top module
  typedef struct packed {
    logic [7:0] gain;
    logic [7:0] phase;
    logic [7:0] amp;
    logic [7:0] mode;
    logic [7:0] pre;
    rmpc_radio_e radio;
    rmpc_radio_e target;
    logic [15:0] cal_cnt;
    logic locked;
    logic [31:0] rdata;
    logic wait_q;
    rmpc_cfg_s cfg;
    rmpc_pins_s pins;
  } rmpc_top_s;

  // state of the lock timer
  typedef struct packed {
    logic busy;
    logic [15:0] cnt;
    logic done;
  } rmpc_lock_s;

  // state of the preamble judge
  typedef struct packed {
    logic [11:0] hist;
    logic [3:0] seen;
    logic found;
  } rmpc_pre_s;

endpackage

// file: verilog/rmpc_preamble_judge.sv
// Purpose: judges the preamble over the last twelve bit pairs
// Assumes: pair_valid/pair_err come from the demodulator in receive
// Notes: clear restarts the window; found is a level until clear
`timescale 1ns/1ps
`include "rmpc_params.svh"
module rmpc_preamble_judge import rmpc_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic [3:0] tol_code,
  // bit pairs
  input wire logic pair_valid,
  input wire logic pair_err,
  // result
  output logic found
);
  rmpc_pre_s st; // current state
  rmpc_pre_s next_st; // next state
  logic [3:0] errs; // wrong pairs in window

  // count ones in the window
  function automatic logic [3:0] pop12(input logic [11:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 12; i++) begin
      n = n + {3'b000, v[i]};
    end
    return n;
  endfunction

  // ==========================================================================
  // sliding window of twelve pairs
  always_comb begin
    next_st = st;
    errs = pop12({st.hist[10:0], pair_err});
    if (clear) begin
      next_st = '0;
    end else if (pair_valid && !st.found) begin
      next_st.hist = {st.hist[10:0], pair_err};
      if (st.seen != `RMPC_PAIRS) begin
        next_st.seen = st.seen + 4'h1;
      end
      // code 0 and reserved codes above twelve never detect
      if (tol_code != `RMPC_TOL_OFF && tol_code <= `RMPC_PAIRS &&
          st.seen >= `RMPC_PAIRS - 4'h1 && errs <= `RMPC_PAIRS - tol_code) begin
        next_st.found = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign found = st.found;
endmodule

// file: verilog/rmpc_top.sv
// Purpose: radio mode and preamble configuration bank with its consumers
// Assumes: avalon-mm slave, byte addresses, 32-bit data; events synchronous
// Notes: one wait state on every access; configuration is 8 bits in the low byte
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`include "rmpc_params.svh"
module rmpc_top import rmpc_pkg::*; #(
  parameter int CAL_CYCLES = 64,
  parameter int LOCK_CYCLES = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // radio commands and events
  input rmpc_evt_s evt,
  input wire logic [15:0] custom_lock_time,
  // configuration and status to the radio
  output rmpc_cfg_s cfg,
  output rmpc_radio_e radio_state,
  output logic freq_loop_locked,
  output logic preamble_found,
  // external amplifier pins
  output rmpc_pins_s pins
);
  // ==========================================================================
  // elaboration checks
  if (CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin : g_chk_cal
    $error("CAL_CYCLES out of range");
  end

  // ==========================================================================
  // declarations
  rmpc_top_s st; // all registered state
  rmpc_top_s next_st; // value for next edge
  logic lock_start; // pulse into lock timer
  logic lock_done; // synthesizer settled
  logic pre_clear; // restart preamble window
  logic pre_found; // preamble accepted
  logic access; // request taken this edge
  logic [7:0] wbyte; // written byte
  logic lock_event; // frequency loop may lock
  logic turn_ok; // turnaround allowed

  // two raised to a four-bit code
  function automatic logic [15:0] pow2(input logic [3:0] code);
    return 16'h0001 << code;
  endfunction

  // address match for one register index
  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    return addr == {idx, 2'b00};
  endfunction

  // ==========================================================================
  // helpers
  rmpc_lock_timer #(
    .LOCK_CYCLES(LOCK_CYCLES)
  ) u_lock (
    .clock(clock),
    .rst_n(rst_n),
    .start(lock_start),
    .custom_en(st.mode[`RMPC_BIT_CUSTOM_LOCK]),
    .custom_cycles(custom_lock_time),
    .done(lock_done)
  );

  rmpc_preamble_judge u_pre (
    .clock(clock),
    .rst_n(rst_n),
    .clear(pre_clear),
    .tol_code(st.pre[`RMPC_TOL_MSB:0]),
    .pair_valid(evt.pair_valid),
    .pair_err(evt.pair_err),
    .found(pre_found)
  );

  // ==========================================================================
  // next state
  always_comb begin
    next_st = st;
    lock_start = 1'b0;
    access = (read || write) && !st.wait_q;
    wbyte = writedata[7:0];
    turn_ok = evt.packet_mode;
    pre_clear = (st.radio != receive_state);
    // frequency loop locks on the preamble, or on sync only with detection off
    if (st.pre[`RMPC_TOL_MSB:0] == `RMPC_TOL_OFF) begin
      lock_event = evt.sync_found;
    end else begin
      lock_event = pre_found;
    end

    // bus handshake: wait one cycle, then answer
    next_st.wait_q = !((read || write) && st.wait_q);
    next_st.rdata = st.rdata;

    // --------------------------------------------------------------
    // register writes, taken at the edge with waitrequest low
    if (access && write) begin
      if (hit(address, `RMPC_IDX_GAIN)) begin
        next_st.gain = wbyte;
      end else if (hit(address, `RMPC_IDX_PHASE)) begin
        next_st.phase = wbyte;
      end else if (hit(address, `RMPC_IDX_AMP)) begin
        next_st.amp = wbyte;
      end else if (hit(address, `RMPC_IDX_MODE)) begin
        next_st.mode = wbyte;
      end else if (hit(address, `RMPC_IDX_PRE)) begin
        next_st.pre = wbyte;
      end
      // other addresses: write ignored
    end

    // --------------------------------------------------------------
    // read data prepared while waitrequest is high
    if (read && st.wait_q) begin
      if (hit(address, `RMPC_IDX_GAIN)) begin
        next_st.rdata = {24'h00_0000, st.gain};
      end else if (hit(address, `RMPC_IDX_PHASE)) begin
        next_st.rdata = {24'h00_0000, st.phase};
      end else if (hit(address, `RMPC_IDX_AMP)) begin
        next_st.rdata = {24'h00_0000, st.amp};
      end else if (hit(address, `RMPC_IDX_MODE)) begin
        next_st.rdata = {24'h00_0000, st.mode};
      end else if (hit(address, `RMPC_IDX_PRE)) begin
        next_st.rdata = {24'h00_0000, st.pre};
      end else if (hit(address, `RMPC_IDX_STATUS)) begin
        // status: radio state, loop lock, preamble seen
        next_st.rdata = {24'h00_0000, 3'b000, pre_found, st.locked, st.radio};
      end else begin
        next_st.rdata = 32'h0000_0000; // unmapped reads as zero
      end
    end

    // --------------------------------------------------------------
    // configuration applied to the datapath, one cycle after a write
    next_st.cfg.freq_loop_prop_gain = st.gain[`RMPC_KP_MSB:`RMPC_KP_LSB];
    next_st.cfg.prop_gain_factor = pow2(st.gain[`RMPC_KP_MSB:`RMPC_KP_LSB]);
    next_st.cfg.freq_loop_int_gain = st.gain[`RMPC_KI_MSB:`RMPC_KI_LSB];
    next_st.cfg.int_gain_factor = pow2(st.gain[`RMPC_KI_MSB:`RMPC_KI_LSB]);
    // bit seven of the trims is stored but never reaches the datapath
    next_st.cfg.iq_phase_value = st.phase[`RMPC_TRIM_MSB:0];
    next_st.cfg.iq_amplitude_value = st.amp[`RMPC_TRIM_MSB:0];
    next_st.cfg.smart_wake_enable = st.mode[`RMPC_BIT_SMART_WAKE];
    next_st.cfg.wake_signal_qualify = st.mode[`RMPC_BIT_WAKE_QUAL];

    // --------------------------------------------------------------
    // radio state machine
    case (st.radio)
      powered_sleep_state: begin
        if (evt.go_off) begin
          next_st.radio = powered_off_state;
        end
      end
      powered_off_state: begin
        if (evt.go_sleep) begin
          next_st.radio = powered_sleep_state;
        end else if (evt.go_on) begin
          // calibration is run on every off-to-on step when enabled
          if (st.mode[`RMPC_BIT_FILTER_CAL]) begin
            next_st.radio = filter_cal_state;
            next_st.cal_cnt = 16'(CAL_CYCLES);
          end else begin
            next_st.radio = powered_on_state;
          end
        end
      end
      filter_cal_state: begin
        if (st.cal_cnt == 16'h0001) begin
          next_st.radio = powered_on_state;
        end else begin
          next_st.cal_cnt = st.cal_cnt - 16'h0001;
        end
      end
      powered_on_state: begin
        if (evt.go_off) begin
          next_st.radio = powered_off_state;
        end else if (evt.go_rx) begin
          next_st.radio = synth_lock_state;
          next_st.target = receive_state;
          lock_start = 1'b1;
        end else if (evt.go_tx) begin
          next_st.radio = synth_lock_state;
          next_st.target = transmit_state;
          lock_start = 1'b1;
        end
      end
      synth_lock_state: begin
        // lock time chosen by the custom lock bit
        if (lock_done) begin
          next_st.radio = st.target;
        end
      end
      receive_state: begin
        if (evt.go_off) begin
          next_st.radio = powered_off_state;
        end else if (evt.go_on) begin
          next_st.radio = powered_on_state;
        end else if (evt.rx_valid_end && turn_ok && st.mode[`RMPC_BIT_LISTEN_SEND]) begin
          // same channel: no frequency change, only resettling
          next_st.radio = synth_lock_state;
          next_st.target = transmit_state;
          lock_start = 1'b1;
        end else if (evt.go_tx) begin
          next_st.radio = synth_lock_state;
          next_st.target = transmit_state;
          lock_start = 1'b1;
        end
      end
      transmit_state: begin
        if (evt.go_off) begin
          next_st.radio = powered_off_state;
        end else if (evt.tx_end) begin
          if (turn_ok && st.mode[`RMPC_BIT_SEND_LISTEN]) begin
            next_st.radio = synth_lock_state;
            next_st.target = receive_state;
            lock_start = 1'b1;
          end else begin
            next_st.radio = powered_on_state;
          end
        end else if (evt.go_on) begin
          next_st.radio = powered_on_state;
        end
      end
      default: begin
        next_st.radio = powered_off_state;
      end
    endcase

    // --------------------------------------------------------------
    // frequency loop lock: only in receive with the lock setting
    // cleared on the edge that leaves receive, so it never outlives the state
    if (next_st.radio != receive_state) begin
      next_st.locked = 1'b0;
    end else if (evt.freq_loop_lock_setting == `RMPC_LOCK_SETTING && lock_event) begin
      next_st.locked = 1'b1;
    end

    // --------------------------------------------------------------
    // external amplifier enables, low in sleep as well
    next_st.pins.test_pin_two_oe = st.mode[`RMPC_BIT_AMP_RX];
    next_st.pins.test_pin_two = st.mode[`RMPC_BIT_AMP_RX] && (next_st.radio == receive_state);
    next_st.pins.test_pin_one_oe = st.mode[`RMPC_BIT_AMP_TX];
    next_st.pins.test_pin_one = st.mode[`RMPC_BIT_AMP_TX] && (next_st.radio == transmit_state);
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
      st.gain <= `RMPC_RST_GAIN;
      st.phase <= `RMPC_RST_ZERO;
      st.amp <= `RMPC_RST_ZERO;
      st.mode <= `RMPC_RST_ZERO;
      st.pre <= `RMPC_RST_ZERO;
      st.radio <= powered_sleep_state;
      st.target <= powered_on_state;
      st.wait_q <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs, all from flip-flops
  assign readdata = st.rdata;
  assign waitrequest = st.wait_q;
  assign cfg = st.cfg;
  assign radio_state = st.radio;
  assign freq_loop_locked = st.locked;
  assign preamble_found = pre_found;
  assign pins = st.pins;
endmodule
